// ### inc/omd_regs.svh
`ifndef OMD_REGS_SVH
`define OMD_REGS_SVH

// internal code/data ram, 16 KB from zero
`define OMD_INT_RAM_LAST 16'h3FFF
// scratch data ram, 0.5 KB
`define OMD_SCRATCH_BASE 16'hE000
`define OMD_SCRATCH_LAST 16'hE1FF
// start of the block where external data strobes stay quiet
`define OMD_QUIET_BASE 16'hE200
`define OMD_WAVE_BASE 16'hE400
`define OMD_WAVE_LAST 16'hE47F
`define OMD_REGS_BASE 16'hE500
`define OMD_REGS_LAST 16'hE6FF
`define OMD_SETUP_BASE 16'hE6B8
`define OMD_SETUP_LAST 16'hE6BF
`define OMD_EP0_BASE 16'hE740
`define OMD_ENDPOINT_ONE_OUT_BUFFER_BASE 16'hE780
`define OMD_ENDPOINT_ONE_IN_BUFFER_BASE 16'hE7C0
`define OMD_ENDPOINT_ONE_IN_BUFFER_LAST 16'hE7FF
`define OMD_EPBIG_BASE 16'hF000
// large buffer geometry
`define OMD_EPBIG_SHIFT 9
`define OMD_FS_PKT_LAST 9'h03F
`define OMD_NUM_CFGS 4'hC

`endif

// ### inc/omd_pkg.sv
package omd_pkg;

  typedef enum logic [3:0] {
    RG_INT_RAM,
    RG_SCRATCH,
    RG_WAVE,
    RG_REGS,
    RG_SETUP,
    RG_EP0,
    RG_ENDPOINT_ONE_OUT_BUFFER,
    RG_ENDPOINT_ONE_IN_BUFFER,
    RG_EPBIG,
    RG_RESERVED,
    RG_EXTERNAL
  } omd_region_type;

  typedef struct packed {
    logic [15:0] addr;
    logic codeRd;
    logic dataRd;
    logic dataWr;
  } omd_cpu_req_type;

  typedef struct packed {
    omd_region_type region;
    logic intRamRd;
    logic intWr;
    logic reservedHit;
    logic [3:0] bigOwner;
    logic bigByteUsable;
  } omd_decode_type;

endpackage

// ### hdl/omd_memory_decoder.sv
// Contract
// - internal 16 KB ram answers data reads, and code reads with select low, strobes ORed
// - no usb control register decodes inside the 16 KB ram region
// - select low: 16 KB ram at zero is combined code and data memory
// - external data strobes stay inactive for any internally resident space
// - usb transfers, setup pointer, boot loader reach only 16 KB and scratch ram
// - select high: low 16 KB code fetched outside, internal ram data only
// - select high: every code fetch anywhere in the 64 KB space uses external code strobe
// - E200 to FFFF holds registers and buffers, external data strobes quiet
// - upper region laid out top down as large buffers, reserved, small buffers, registers, waveform, ram
// - 8-byte setup data buffer decodes at E6B8 through E6BF
// - three 64-byte small buffers plus eight 512-byte large buffers
// - fourth and eighth endpoints at most double, second and sixth up to quad
// - endpoint zero sole control, endpoint one bulk or interrupt, never changed
// - large buffers take exactly one of twelve arrangements at a time
// - full speed uses first 64 bytes of each large buffer only
`timescale 1ns/10ps
`include "omd_regs.svh"

module omd_memory_decoder #(
  parameter int NUM_BIG_BUFS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire omd_pkg::omd_cpu_req_type cpuReq,
  input wire logic codeSpaceSelect,
  input wire logic highSpeed,
  input wire logic [3:0] bufCfgIn,
  input wire logic bufCfgLoad,
  input wire logic [15:0] loaderAddr,
  input wire logic loaderReq,
  output logic codeReadStrobeN,
  output logic extDataRdN,
  output logic extDataWrN,
  output omd_pkg::omd_decode_type decodeOut,
  output logic [3:0] bufCfgCur,
  output logic loaderGrant,
  output logic loaderReject,
  output logic ep1BulkOrIntOnly
);

  if (NUM_BIG_BUFS != 8) begin
    $error("omd_memory_decoder serves exactly eight large buffers");
  end

  // arrangement table: large buffer counts for endpoints 2,4,6,8
  function automatic logic [11:0] cfg_counts(input logic [3:0] cfg);
    case (cfg)
      4'h0: cfg_counts = {3'h2, 3'h2, 3'h2, 3'h2};
      4'h1: cfg_counts = {3'h2, 3'h2, 3'h4, 3'h0};
      4'h2: cfg_counts = {3'h4, 3'h0, 3'h2, 3'h2};
      4'h3: cfg_counts = {3'h4, 3'h0, 3'h4, 3'h0};
      4'h4: cfg_counts = {3'h3, 3'h0, 3'h3, 3'h2};
      4'h5: cfg_counts = {3'h3, 3'h2, 3'h3, 3'h0};
      4'h6: cfg_counts = {3'h2, 3'h2, 3'h3, 3'h0};
      4'h7: cfg_counts = {3'h3, 3'h0, 3'h2, 3'h2};
      4'h8: cfg_counts = {3'h2, 3'h0, 3'h4, 3'h0};
      4'h9: cfg_counts = {3'h4, 3'h2, 3'h2, 3'h0};
      4'hA: cfg_counts = {3'h2, 3'h2, 3'h2, 3'h0};
      4'hB: cfg_counts = {3'h4, 3'h2, 3'h0, 3'h2};
      default: cfg_counts = 12'h000;
    endcase
  endfunction

  // owning endpoint of a large buffer, zero when unassigned
  function automatic logic [3:0] big_owner(input logic [3:0] cfg, input logic [2:0] idx);
    logic [11:0] c;
    logic [3:0] e2, e4, e6, e8;
    c = cfg_counts(cfg);
    e2 = {1'b0, c[11:9]};
    e4 = e2 + {1'b0, c[8:6]};
    e6 = e4 + {1'b0, c[5:3]};
    e8 = e6 + {1'b0, c[2:0]};
    if ({1'b0, idx} < e2) begin
      big_owner = 4'h2;
    end else if ({1'b0, idx} < e4) begin
      big_owner = 4'h4;
    end else if ({1'b0, idx} < e6) begin
      big_owner = 4'h6;
    end else if ({1'b0, idx} < e8) begin
      big_owner = 4'h8;
    end else begin
      big_owner = 4'h0;
    end
  endfunction

  // code space select pin synchroniser
  logic selMeta_q, selSync_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selMeta_q <= 1'b0;
      selSync_q <= 1'b0;
    end else begin
      selMeta_q <= codeSpaceSelect;
      selSync_q <= selMeta_q;
    end
  end

  // arrangement register
  logic [3:0] bufCfg_d, bufCfg_q;
  always_comb begin
    bufCfg_d = bufCfg_q;
    if (bufCfgLoad && bufCfgIn < `OMD_NUM_CFGS) begin
      bufCfg_d = bufCfgIn;
    end
  end

  // region decode
  omd_pkg::omd_region_type region;
  logic [15:0] a;
  logic inLowRam, quietData, intCode;
  always_comb begin
    a = cpuReq.addr;
    inLowRam = a <= `OMD_INT_RAM_LAST;
    if (inLowRam) begin
      region = omd_pkg::RG_INT_RAM;
    end else if (a < `OMD_SCRATCH_BASE) begin
      region = omd_pkg::RG_EXTERNAL;
    end else if (a <= `OMD_SCRATCH_LAST) begin
      region = omd_pkg::RG_SCRATCH;
    end else if (a >= `OMD_EPBIG_BASE) begin
      region = omd_pkg::RG_EPBIG;
    end else if (a >= `OMD_ENDPOINT_ONE_IN_BUFFER_BASE && a <= `OMD_ENDPOINT_ONE_IN_BUFFER_LAST) begin
      region = omd_pkg::RG_ENDPOINT_ONE_IN_BUFFER;
    end else if (a >= `OMD_ENDPOINT_ONE_OUT_BUFFER_BASE && a < `OMD_ENDPOINT_ONE_IN_BUFFER_BASE) begin
      region = omd_pkg::RG_ENDPOINT_ONE_OUT_BUFFER;
    end else if (a >= `OMD_EP0_BASE && a < `OMD_ENDPOINT_ONE_OUT_BUFFER_BASE) begin
      region = omd_pkg::RG_EP0;
    end else if (a >= `OMD_SETUP_BASE && a <= `OMD_SETUP_LAST) begin
      region = omd_pkg::RG_SETUP;
    end else if (a >= `OMD_REGS_BASE && a <= `OMD_REGS_LAST) begin
      region = omd_pkg::RG_REGS;
    end else if (a >= `OMD_WAVE_BASE && a <= `OMD_WAVE_LAST) begin
      region = omd_pkg::RG_WAVE;
    end else begin
      region = omd_pkg::RG_RESERVED;
    end
    quietData = inLowRam || a >= `OMD_SCRATCH_BASE;
    intCode = !selSync_q && inLowRam;
  end

  // next outputs, all decode is same-cycle, then registered together
  logic codeRdN_d, codeRdN_q, dataRdN_d, dataRdN_q, dataWrN_d, dataWrN_q;
  logic grant_d, grant_q, reject_d, reject_q;
  logic ep1Fixed_d, ep1Fixed_q;
  omd_pkg::omd_decode_type dec_d, dec_q;
  logic [8:0] bigOff;
  always_comb begin
    bigOff = a[8:0];
    dec_d.region = region;
    dec_d.intRamRd = inLowRam && (cpuReq.dataRd || (cpuReq.codeRd && intCode));
    dec_d.intWr = cpuReq.dataWr && quietData && region != omd_pkg::RG_RESERVED;
    dec_d.reservedHit = region == omd_pkg::RG_RESERVED && (cpuReq.dataRd || cpuReq.dataWr);
    dec_d.bigOwner = 4'h0;
    dec_d.bigByteUsable = 1'b0;
    if (region == omd_pkg::RG_EPBIG) begin
      dec_d.bigOwner = big_owner(bufCfg_q, a[11:`OMD_EPBIG_SHIFT]);
      dec_d.bigByteUsable = dec_d.bigOwner != 4'h0 && (highSpeed || bigOff <= `OMD_FS_PKT_LAST);
    end
    codeRdN_d = !(cpuReq.codeRd && !intCode);
    dataRdN_d = !(cpuReq.dataRd && !quietData);
    dataWrN_d = !(cpuReq.dataWr && !quietData);
    grant_d = loaderReq && (loaderAddr <= `OMD_INT_RAM_LAST ||
      (loaderAddr >= `OMD_SCRATCH_BASE && loaderAddr <= `OMD_SCRATCH_LAST));
    reject_d = loaderReq && !grant_d;
    ep1Fixed_d = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufCfg_q <= 4'h0;
      codeRdN_q <= 1'b1;
      dataRdN_q <= 1'b1;
      dataWrN_q <= 1'b1;
      grant_q <= 1'b0;
      reject_q <= 1'b0;
      ep1Fixed_q <= 1'b1;
      dec_q <= '{omd_pkg::RG_INT_RAM, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0};
    end else begin
      bufCfg_q <= bufCfg_d;
      codeRdN_q <= codeRdN_d;
      dataRdN_q <= dataRdN_d;
      dataWrN_q <= dataWrN_d;
      grant_q <= grant_d;
      reject_q <= reject_d;
      ep1Fixed_q <= ep1Fixed_d;
      dec_q <= dec_d;
    end
  end

  assign codeReadStrobeN = codeRdN_q;
  assign extDataRdN = dataRdN_q;
  assign extDataWrN = dataWrN_q;
  assign decodeOut = dec_q;
  assign bufCfgCur = bufCfg_q;
  assign loaderGrant = grant_q;
  assign loaderReject = reject_q;
  assign ep1BulkOrIntOnly = ep1Fixed_q;

  // checks
  sequence quiet_data_access;
    (cpuReq.dataRd || cpuReq.dataWr) && (cpuReq.addr <= 16'h3FFF || cpuReq.addr >= 16'hE000);
  endsequence

  chk_quiet_strobes: assert property (@(posedge clk) disable iff (rst)
    quiet_data_access |=> extDataRdN && extDataWrN)
    else $error("external data strobe active for internal space");

  chk_upper_quiet: assert property (@(posedge clk) disable iff (rst)
    cpuReq.dataWr && cpuReq.addr >= 16'hE200 |=> extDataWrN && decodeOut.region != omd_pkg::RG_EXTERNAL)
    else $error("write to upper block escaped");

  chk_ext_write: assert property (@(posedge clk) disable iff (rst)
    cpuReq.dataWr && cpuReq.addr > 16'h3FFF && cpuReq.addr < 16'hE000 |=> !extDataWrN)
    else $error("external write strobe missing");

  chk_code_ext: assert property (@(posedge clk) disable iff (rst)
    cpuReq.codeRd && selSync_q |=> !codeReadStrobeN && !decodeOut.intRamRd)
    else $error("code fetch not external with select high");

  chk_code_int: assert property (@(posedge clk) disable iff (rst)
    cpuReq.codeRd && !selSync_q && cpuReq.addr <= 16'h3FFF |=> codeReadStrobeN && decodeOut.intRamRd)
    else $error("low code fetch not served inside");

  chk_ram_or: assert property (@(posedge clk) disable iff (rst)
    cpuReq.dataRd && cpuReq.addr <= 16'h3FFF |=> decodeOut.intRamRd && decodeOut.region == omd_pkg::RG_INT_RAM)
    else $error("data read of ram not served inside");

  chk_loader_range: assert property (@(posedge clk) disable iff (rst)
    loaderReq && loaderAddr > 16'h3FFF && (loaderAddr < 16'hE000 || loaderAddr > 16'hE1FF)
      |=> loaderReject && !loaderGrant)
    else $error("loader reached forbidden region");

  chk_setup_buf: assert property (@(posedge clk) disable iff (rst)
    cpuReq.addr >= 16'hE6B8 && cpuReq.addr <= 16'hE6BF |=> decodeOut.region == omd_pkg::RG_SETUP)
    else $error("setup buffer not decoded");

  chk_cfg_legal: assert property (@(posedge clk) disable iff (rst)
    bufCfgLoad && bufCfgIn > 4'hB |=> bufCfgCur == $past(bufCfgCur))
    else $error("illegal arrangement accepted");

  chk_fs_limit: assert property (@(posedge clk) disable iff (rst)
    !highSpeed && cpuReq.addr >= 16'hF000 && cpuReq.addr[8:0] > 9'h03F |=> !decodeOut.bigByteUsable)
    else $error("full speed byte beyond packet used");

  chk_reserved_wr: assert property (@(posedge clk) disable iff (rst)
    cpuReq.dataWr && cpuReq.addr >= 16'hE800 && cpuReq.addr < 16'hF000 |=> !decodeOut.intWr && extDataWrN)
    else $error("reserved write not ignored");

endmodule

// ### bench/omd_ext_mem.sv
`timescale 1ns/10ps
module omd_ext_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic codeRdN,
  input wire logic dataRdN,
  input wire logic dataWrN,
  output int codeCnt,
  output int rdCnt,
  output int wrCnt
);
  // counts every cycle in which an external strobe is active
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      codeCnt <= 0;
      rdCnt <= 0;
      wrCnt <= 0;
    end else begin
      codeCnt <= codeCnt + int'(!codeRdN);
      rdCnt <= rdCnt + int'(!dataRdN);
      wrCnt <= wrCnt + int'(!dataWrN);
    end
  end
endmodule

// ### bench/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst = 1, sel = 0, hs = 0, ld = 0, lr = 0;
  logic [3:0] ci = 4'h0, cfgM = 4'h0;
  logic [15:0] la = 16'h0000;
  omd_pkg::omd_cpu_req_type req = '0;
  logic cRdN, dRdN, dWrN, grant, rej, ep1;
  omd_pkg::omd_decode_type dec;
  logic [3:0] cfgCur;
  logic [31:0] rnd = 32'hEDECD744;
  logic eC = 1, eR = 1, eW = 1, eIw = 0, eRes = 0, eUse = 0, eG = 0, eJ = 0, eRam = 0;
  logic [3:0] eOwner = 4'h0;
  omd_pkg::omd_region_type eRg = omd_pkg::RG_INT_RAM;
  int bad_count = 0, cmp_count = 0, cyc = 0, nC = 0, nR = 0, nW = 0, pC, pR, pW;
  logic [15:0] tbl [12] = '{16'h2222, 16'h2240, 16'h4022, 16'h4040, 16'h3032, 16'h3230,
                            16'h2230, 16'h3022, 16'h2040, 16'h4220, 16'h2220, 16'h4202};
  logic [15:0] pts [27] = '{16'h0000, 16'h3FFF, 16'h4000, 16'hDFFF, 16'hE000, 16'hE1FF, 16'hE200,
    16'hE3FF, 16'hE400, 16'hE47F, 16'hE480, 16'hE500, 16'hE6B7, 16'hE6B8, 16'hE6BF, 16'hE6C0,
    16'hE6FF, 16'hE700, 16'hE740, 16'hE780, 16'hE7C0, 16'hE7FF, 16'hE800, 16'hF000, 16'hF03F,
    16'hF040, 16'hFFFF};
  omd_memory_decoder omd_memory_decoder_inst (.clk(clk), .rst(rst), .cpuReq(req),
    .codeSpaceSelect(sel), .highSpeed(hs), .bufCfgIn(ci), .bufCfgLoad(ld), .loaderAddr(la),
    .loaderReq(lr), .codeReadStrobeN(cRdN), .extDataRdN(dRdN), .extDataWrN(dWrN),
    .decodeOut(dec), .bufCfgCur(cfgCur), .loaderGrant(grant), .loaderReject(rej),
    .ep1BulkOrIntOnly(ep1));
  omd_ext_mem omd_ext_mem_inst (.clk(clk), .rst(rst), .codeRdN(cRdN), .dataRdN(dRdN),
    .dataWrN(dWrN), .codeCnt(pC), .rdCnt(pR), .wrCnt(pW));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic omd_pkg::omd_region_type regionOf(input logic [15:0] a);
    if (a <= 16'h3FFF) return omd_pkg::RG_INT_RAM;
    if (a <= 16'hDFFF) return omd_pkg::RG_EXTERNAL;
    if (a <= 16'hE1FF) return omd_pkg::RG_SCRATCH;
    if (a >= 16'hE400 && a <= 16'hE47F) return omd_pkg::RG_WAVE;
    if (a >= 16'hE6B8 && a <= 16'hE6BF) return omd_pkg::RG_SETUP;
    if (a >= 16'hE500 && a <= 16'hE6FF) return omd_pkg::RG_REGS;
    if (a >= 16'hE740 && a <= 16'hE77F) return omd_pkg::RG_EP0;
    if (a >= 16'hE780 && a <= 16'hE7BF) return omd_pkg::RG_ENDPOINT_ONE_OUT_BUFFER;
    if (a >= 16'hE7C0 && a <= 16'hE7FF) return omd_pkg::RG_ENDPOINT_ONE_IN_BUFFER;
    if (a >= 16'hF000) return omd_pkg::RG_EPBIG;
    return omd_pkg::RG_RESERVED;
  endfunction
  function automatic logic [3:0] ownerOf(input logic [3:0] c, input int i);
    int acc = 0;
    for (int k = 0; k < 4; k++) begin
      acc += int'((tbl[c] >> (12 - 4 * k)) & 16'h000F);
      if (i < acc) return 4'(2 + 2 * k);
    end
    return 4'h0;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic step(input logic [15:0] a, input logic [1:0] op, input logic l, input logic [3:0] c,
                      input logic r, input logic [15:0] lad);
    @(posedge clk);
    #1;
    check(cRdN, eC);
    check(dRdN, eR);
    check(dWrN, eW);
    check(grant, eG);
    check(rej, eJ);
    check(cfgCur, cfgM);
    check(ep1, 1'b1);
    check(dec.region, eRg);
    check(dec.reservedHit, eRes);
    check(dec.intWr, eIw);
    check(dec.intRamRd, eRam);
    check(dec.bigOwner, eOwner);
    check(dec.bigByteUsable, eUse);
    rnd = lfsr(rnd);
    hs = rnd[30];
    req = '{addr: a, codeRd: op == 2'd1, dataRd: op == 2'd2, dataWr: op == 2'd3};
    ld = l;
    ci = c;
    lr = r;
    la = lad;
    eRg = regionOf(a);
    eC = !(op == 2'd1 && (sel || a > 16'h3FFF));
    eR = !(op == 2'd2 && eRg == omd_pkg::RG_EXTERNAL);
    eW = !(op == 2'd3 && eRg == omd_pkg::RG_EXTERNAL);
    eRes = eRg == omd_pkg::RG_RESERVED && op[1];
    eIw = op == 2'h3 && eRg != omd_pkg::RG_RESERVED && eRg != omd_pkg::RG_EXTERNAL;
    eRam = a <= 16'h3FFF && (op == 2'h2 || (op == 2'h1 && !sel));
    eOwner = (eRg == omd_pkg::RG_EPBIG) ? ownerOf(cfgM, int'(a[11:9])) : 4'h0;
    eUse = eOwner != 4'h0 && (hs || a[8:0] <= 9'h03F);
    eG = r && (lad <= 16'h3FFF || (lad >= 16'hE000 && lad <= 16'hE1FF));
    eJ = r && !eG;
    nC += int'(!eC);
    nR += int'(!eR);
    nW += int'(!eW);
    if (l && c <= 4'hB) cfgM = c;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      repeat (3) step(16'h0000, 2'd0, 0, 4'h0, 0, 16'h0000);
      foreach (pts[i]) for (int o = 1; o < 4; o++) step(pts[i], 2'(o), 0, 4'h0, 1, pts[i]);
    end
    for (int c = 0; c < 16; c++) begin
      step(16'h0000, 2'd0, 1, 4'(c), 0, 16'h0000);
      for (int i = 0; i < 16; i++) step(16'hF000 + 16'(i * 256) + 16'(i * 4), 2'd2, 0, 4'h0, 0, 16'h0000);
    end
    for (int n = 0; n < 3000; n++) begin
      step(rnd[15:0], rnd[17:16], rnd[20:18] == 3'h0, rnd[24:21], rnd[25], {rnd[28:26], rnd[12:0]});
    end
    repeat (2) step(16'h0000, 2'd0, 0, 4'h0, 0, 16'h0000);
    check(16'(pC), 16'(nC));
    check(16'(pR), 16'(nR));
    check(16'(pW), 16'(nW));
    summarize();
  end
endmodule
